// >>> bench/tmc_src.sv
/*
  External pulse source: square wave of num_in periods, half_in cycles a phase.
  Assumes the bench keeps half_in above the minimum phase width.
*/
`timescale 1ns/1ps
module tmc_src (
  // Clock
  input wire logic clk_in,
  // Control
  input wire logic run_in,
  input wire logic [15:0] half_in,
  input wire logic [7:0] num_in,
  // Pin
  output logic level_out,
  output logic done_out
);
  logic [15:0] cnt;
  logic [8:0] tog;
  // Idle low between bursts so a stop never leaves a half pulse behind
  always_ff @(posedge clk_in) begin
    if (!run_in) begin
      cnt <= 16'h0000;
      tog <= 9'h000;
      level_out <= 1'b0;
    end else if (tog != {num_in, 1'b0}) begin
      if (cnt == half_in - 16'h0001) begin
        cnt <= 16'h0000;
        tog <= tog + 9'h001;
        level_out <= !level_out;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
  assign done_out = run_in && (tog == {num_in, 1'b0});
endmodule

// >>> bench/tmc_timer_props.sv
/*
  Checker for the timer: bus handshake, reset state and event pulses.
  Sees only the top ports; bound to tmc_timer at the foot.
*/
`timescale 1ns/1ps
module tmc_timer_props (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // Bus
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Events
  input wire logic MATCH_PULSE_OUT,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_take;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence s_ack_once;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence
  sequence s_pulse_once;
    MATCH_PULSE_OUT ##1 !MATCH_PULSE_OUT;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  ack_delay_a: assert property (s_take |=> WB_ACK_OUT) else $error("ack not given");
  ack_single_a: assert property (WB_ACK_OUT |-> s_ack_once) else $error("ack too long");
  ack_cause_a: assert property (!(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT)
    else $error("ack without request");
  rst_quiet_a: assert property ($fell(SYS_RST_IN) |-> !WB_ACK_OUT && !IRQ_OUT && !MATCH_PULSE_OUT)
    else $error("outputs busy after reset");
  rst_data_a: assert property ($fell(SYS_RST_IN) |-> WB_DAT_OUT == 32'h0)
    else $error("read data not cleared by reset");
  pulse_single_a: assert property (MATCH_PULSE_OUT |-> s_pulse_once)
    else $error("event pulse too long");
  pulse_gap_a: assert property ($fell(MATCH_PULSE_OUT) |-> !MATCH_PULSE_OUT [*8])
    else $error("event pulses too close");
  // Sticky status means the level may only drop after a bus write
  irq_fall_a: assert property ($fell(IRQ_OUT) |-> $past(WB_ACK_OUT && WB_WE_IN)
    || $past(WB_ACK_OUT && WB_WE_IN, 2) || $past(WB_ACK_OUT && WB_WE_IN, 3))
    else $error("irq dropped without write");
endmodule

bind tmc_timer tmc_timer_props i_props (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN),
  .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .MATCH_PULSE_OUT(MATCH_PULSE_OUT),
  .IRQ_OUT(IRQ_OUT));

// >>> bench/tmc_timer_test.sv
/*
  Self-checking bench for the timer: capture, overflow, event and timer modes.
  Assumes the pulse source model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tmc_timer_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, pulse_o, irq, src_lvl, src_done;
  logic src_run = 1'b0;
  logic [15:0] src_half = 16'h001E;
  logic [7:0] src_num = 8'h01;
  int err_count = 0;
  int total_checks = 0;
  int pulses = 0;
  int cyc_n = 0;
  int seed = 1;
  int n, p0, t0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (pulse_o === 1'b1) pulses <= pulses + 1;
  end
  tmc_timer i_dut (.MCLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .EXT_COUNT_IN(src_lvl === 1'b1), .MATCH_PULSE_OUT(pulse_o), .IRQ_OUT(irq));
  tmc_src i_src (.clk_in(clk), .run_in(src_run), .half_in(src_half), .num_in(src_num),
    .level_out(src_lvl), .done_out(src_done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk iff ack === 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask
  // Prescaler phase is unknown, so captured widths may be off by one tick
  task automatic rd_rng(input string what, input logic [7:0] a, input int lo, input int hi);
    wb(1'b0, a, 32'h0);
    total_checks++;
    if ($isunknown(q) || q < lo || q > hi) begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %h", what, lo, hi, q);
    end
  endtask
  task automatic src_go(input logic [15:0] h, input logic [7:0] k);
    @(posedge clk);
    src_half <= h;
    src_num <= k;
    src_run <= 1'b1;
  endtask
  task automatic src_wait;
    @(posedge clk iff src_done === 1'b1);
    src_run <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk("cca reset", tmc_pkg::TMC_OFF_CCA, {24'h0, tmc_pkg::TMC_CCA_RST});
    rd_chk("capb reset", tmc_pkg::TMC_OFF_CAPB, {24'h0, tmc_pkg::TMC_CAPB_RST});
    rd_chk("ctrl reset", tmc_pkg::TMC_OFF_CTRL, 32'h0);
    rd_chk("cnt reset", tmc_pkg::TMC_OFF_CNT, 32'h0);
    rd_chk("unmapped", 8'h1C, 32'h0);
    wb(1'b1, tmc_pkg::TMC_OFF_MASK, 32'h7);
    for (int inv = 0; inv < 2; inv++) begin
      wb(1'b1, tmc_pkg::TMC_OFF_EDGE, 32'(inv));
      wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h0E);
      wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h1E);
      p0 = pulses;
      src_go(16'h0500, 8'h02);
      if (inv == 0) begin
        repeat (1320) @(posedge clk);
        check("first edge", 32'(p0 + 1), 32'(pulses));
        rd_chk("capb kept", tmc_pkg::TMC_OFF_CAPB, 32'hFF);
      end
      src_wait;
      check("capture pulses", 32'(p0 + 2), 32'(pulses));
      rd_rng("capb width", tmc_pkg::TMC_OFF_CAPB, 4, 6);
      rd_rng("cca period", tmc_pkg::TMC_OFF_CCA, 9, 11);
      wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h0);
    end
    wb(1'b1, tmc_pkg::TMC_OFF_EDGE, 32'h0);
    wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h1E);
    p0 = pulses;
    @(posedge clk iff pulse_o === 1'b1);
    src_go(16'h0500, 8'h01);
    src_wait;
    check("suspended", 32'(p0 + 1), 32'(pulses));
    wb(1'b0, tmc_pkg::TMC_OFF_CAPB, 32'h0);
    rd_chk("ovf cca", tmc_pkg::TMC_OFF_CCA, 32'hFF);
    src_go(16'h0500, 8'h01);
    src_wait;
    check("resumed", 32'(p0 + 2), 32'(pulses));
    wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h0);
    for (int inv = 0; inv < 2; inv++) begin
      n = 2 + ($unsigned($random(seed)) % 4);
      wb(1'b1, tmc_pkg::TMC_OFF_STAT, 32'h7);
      wb(1'b1, tmc_pkg::TMC_OFF_MASK, 32'(inv));
      wb(1'b1, tmc_pkg::TMC_OFF_CCA, 32'(n));
      wb(1'b1, tmc_pkg::TMC_OFF_EDGE, 32'(inv));
      wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h47);
      wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h57);
      p0 = pulses;
      src_go(16'h001E, 8'(n + 1));
      src_wait;
      check("event pulses", 32'(p0 + 1), 32'(pulses));
      rd_chk("event count", tmc_pkg::TMC_OFF_CNT, 32'h1);
      rd_chk("live copy", tmc_pkg::TMC_OFF_CAPB, 32'h1);
      rd_chk("status", tmc_pkg::TMC_OFF_STAT, 32'h1);
      check("irq masked", 32'(inv), {31'h0, irq});
      wb(1'b1, tmc_pkg::TMC_OFF_STAT, 32'h1);
      rd_chk("status clear", tmc_pkg::TMC_OFF_STAT, 32'h0);
      check("irq clear", 32'h0, {31'h0, irq});
      wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h0);
    end
    n = 2 + ($unsigned($random(seed)) % 3);
    wb(1'b1, tmc_pkg::TMC_OFF_CCA, 32'(n));
    wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h16);
    @(posedge clk iff pulse_o === 1'b1);
    t0 = cyc_n;
    @(posedge clk iff pulse_o === 1'b1);
    check("timer period", 32'h1, {31'h0, (cyc_n - t0 == n * 256)
      || (cyc_n - t0 == (n + 1) * 256)});
    wb(1'b1, tmc_pkg::TMC_OFF_CTRL, 32'h0);
    rd_chk("stopped", tmc_pkg::TMC_OFF_CNT, 32'h0);
    tally_and_finish;
  end
endmodule

// >>> rtl/tmc_pkg.sv
/*
  Package for the 8-bit timer/counter with capture.
  Holds register offsets, field positions, reset values and cycle counts.
  Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
*/
package tmc_pkg;

  // Register byte offsets
  localparam logic [7:0] TMC_OFF_CTRL = 8'h00;
  localparam logic [7:0] TMC_OFF_EDGE = 8'h04;
  localparam logic [7:0] TMC_OFF_CCA = 8'h08;
  localparam logic [7:0] TMC_OFF_CAPB = 8'h0C;
  localparam logic [7:0] TMC_OFF_STAT = 8'h10;
  localparam logic [7:0] TMC_OFF_MASK = 8'h14;
  localparam logic [7:0] TMC_OFF_CNT = 8'h18;

  // Control register field positions
  localparam int TMC_CTRL_CLK_LSB = 0;
  localparam int TMC_CTRL_MODE_BIT = 3;
  localparam int TMC_CTRL_RUN_BIT = 4;
  localparam int TMC_CTRL_AUTO_CAPTURE_EN_BIT = 6;

  // Status / mask bit positions
  localparam int TMC_ST_MATCH = 0;
  localparam int TMC_ST_CAPT = 1;
  localparam int TMC_ST_OVF = 2;

  // Reset values, counter maximum and external clock select code
  localparam logic [7:0] TMC_CCA_RST = 8'hFF;
  localparam logic [7:0] TMC_CAPB_RST = 8'hFF;
  localparam logic [7:0] TMC_CNT_MAX = 8'hFF;
  localparam logic [2:0] TMC_CLK_EXT = 3'h7;

  // Prescaler: code 000 takes the slowest tap, 110 the fastest
  localparam int TMC_PRE_WIDTH = 14;
  localparam int TMC_PRE_SLOW_TAP = 13;

  // External pulse minimum width, 25 periods of the high-frequency clock
  localparam int TMC_MIN_PULSE_NS = 250;
  localparam int TMC_CLK_PERIOD_NS = 10;
  localparam int TMC_MIN_PULSE_CYC = TMC_MIN_PULSE_NS / TMC_CLK_PERIOD_NS;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic capture_mode;
    logic run;
    logic auto_cap;
  } tmc_ctrl_t;

  typedef struct packed {
    logic ovf;
    logic capt;
    logic match;
  } tmc_evt_t;

endpackage

// >>> rtl/tmc_sync.sv
/*
  Three-flop input synchroniser with agreement filter.
  Assumes the input is asynchronous to clk_in; the output changes only once
  the second and third flops agree.
*/
`timescale 1ns/1ps
module tmc_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Signals
  input wire logic async_in,
  output logic sync_out
);

  logic meta;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      meta <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_out <= 1'b0;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end

endmodule

// >>> rtl/tmc_timer.sv
/*
  8-bit timer/counter with timer, event counter and capture modes.
  Assumes a classic Wishbone master on MCLK_IN and an external pulse source
  on EXT_COUNT_IN that is asynchronous to the clock.
*/
// Overview of operation
// - Timer counts tap; match raises irq, clears
// - Auto capture copies live count into capture_b
// - Zero after match not copied into capture_b for one cycle
// - Event mode counts selected external input edge
// - Event match detected on opposite edge
// - Invert 0: fall to B, rise to A
// - Invert 1: rise to B, fall to A
// - First edge interrupt captures A only
// - Capture overflow: irq, A all ones, clear
// - After overflow wait for A read
// - Clock select 000-110 taps, 111 external (capture mode: tap 6)
// - Event invert 0 rising, 1 falling
// - Mode select 0 timer/event, 1 capture
// - Run 0 stops and clears counter
`timescale 1ns/1ps
module tmc_timer (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // External pin
  input wire logic EXT_COUNT_IN,
  // Interrupts
  output logic MATCH_PULSE_OUT,
  output logic IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  tmc_pkg::tmc_ctrl_t ctrl;
  logic edge_inv;
  logic [7:0] cca;
  logic [7:0] capb;
  logic [7:0] cnt;
  tmc_pkg::tmc_evt_t status;
  tmc_pkg::tmc_evt_t mask;
  tmc_pkg::tmc_evt_t evt;
  logic [tmc_pkg::TMC_PRE_WIDTH-1:0] pre;
  logic [tmc_pkg::TMC_PRE_WIDTH-1:0] pre_d;
  logic tick_int;
  logic ext_sync;
  logic ext_d;
  logic ext_rise;
  logic ext_fall;
  logic cnt_edge;
  logic opp_edge;
  logic src_tick;
  // Set by a capture-mode wrap, cleared by a read of the compare register
  logic cap_hold;
  logic after_match;
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic rd_cca;
  logic match_hit;
  logic next_cap_b_timer;

  typedef enum logic [2:0] {
    TMC_ST_STOP = 3'b001,
    TMC_ST_WAIT = 3'b010,
    TMC_ST_RUN = 3'b100
  } tmc_state_t;

  tmc_state_t state;

  function automatic logic [7:0] byte_merge(input logic [7:0] old,
                                            input logic [31:0] dat,
                                            input logic lane);
    byte_merge = lane ? dat[7:0] : old;
  endfunction

  // Lane 0 write strobe for one register offset
  function automatic logic reg_write(input logic wr,
                                     input logic [3:0] sel,
                                     input logic [7:0] adr,
                                     input logic [7:0] off);
    reg_write = wr && sel[0] && (adr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, dropped the next cycle
  // Writes land on the taking edge, one edge before the master sees ack;
  // the master holds the request until then, so nothing is lost

  assign wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign wb_wr = wb_req && WB_WE_IN;
  assign wb_rd = wb_req && !WB_WE_IN;
  assign rd_cca = wb_rd && (WB_ADR_IN == tmc_pkg::TMC_OFF_CCA);

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      WB_ACK_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= wb_req;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      WB_DAT_OUT <= 32'h0000_0000;
    end else if (wb_rd) begin
      // Read data then stands until the next read replaces it
      if (WB_ADR_IN == tmc_pkg::TMC_OFF_CTRL) begin
        WB_DAT_OUT <= {25'h0, ctrl.auto_cap, 1'b0, ctrl.run, ctrl.capture_mode,
                       ctrl.clk_sel};
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_EDGE) begin
        WB_DAT_OUT <= {31'h0, edge_inv};
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_CCA) begin
        WB_DAT_OUT <= {24'h0, cca};
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_CAPB) begin
        WB_DAT_OUT <= {24'h0, capb};
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_STAT) begin
        WB_DAT_OUT <= {29'h0, status};
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_MASK) begin
        WB_DAT_OUT <= {29'h0, mask};
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_CNT) begin
        WB_DAT_OUT <= {24'h0, cnt};
      end else begin
        // Unmapped offsets read as zero and still acknowledge
        WB_DAT_OUT <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  // Mode and clock select should only change while stopped; a change
  // while running is taken at once and may spoil the current count

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      ctrl <= '0;
      edge_inv <= 1'b0;
      mask <= '0;
    end else if (wb_wr && WB_SEL_IN[0]) begin
      if (WB_ADR_IN == tmc_pkg::TMC_OFF_CTRL) begin
        ctrl.clk_sel <= WB_DAT_IN[tmc_pkg::TMC_CTRL_CLK_LSB +: 3];
        ctrl.capture_mode <= WB_DAT_IN[tmc_pkg::TMC_CTRL_MODE_BIT];
        ctrl.run <= WB_DAT_IN[tmc_pkg::TMC_CTRL_RUN_BIT];
        ctrl.auto_cap <= WB_DAT_IN[tmc_pkg::TMC_CTRL_AUTO_CAPTURE_EN_BIT];
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_EDGE) begin
        edge_inv <= WB_DAT_IN[0];
      end else if (WB_ADR_IN == tmc_pkg::TMC_OFF_MASK) begin
        mask <= WB_DAT_IN[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and source clock
  // Free-running, so every tap keeps its phase across stop and start

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      pre <= '0;
      pre_d <= '0;
    end else begin
      pre <= pre + 1'b1;
      pre_d <= pre;
    end
  end

  // Rising transition of the chosen tap; higher code means a faster tap
  // A code change while running may make the first tick short or long
  always_comb begin
    int tap;
    tap = tmc_pkg::TMC_PRE_SLOW_TAP - int'(ctrl.clk_sel);
    tick_int = pre[tap] && !pre_d[tap];
  end

  // Pin edges reach the counter about four clocks after the pin moves
  tmc_sync u_sync (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .async_in(EXT_COUNT_IN),
    .sync_out(ext_sync)
  );

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      ext_d <= 1'b0;
    end else begin
      ext_d <= ext_sync;
    end
  end

  assign ext_rise = ext_sync && !ext_d;
  assign ext_fall = !ext_sync && ext_d;
  // Input width is assumed wide enough for the filter to see each phase
  assign cnt_edge = edge_inv ? ext_fall : ext_rise;
  assign opp_edge = edge_inv ? ext_rise : ext_fall;
  // Code 111 counts pin edges; capture mode then still ticks on prescaler tap 6
  assign src_tick = (ctrl.clk_sel == tmc_pkg::TMC_CLK_EXT) ? cnt_edge : tick_int;

  ////////////////////////////////////////////////////////////////////////////
  // Run state
  // One wait cycle after start lets the cleared counter settle first, so
  // the first tick or edge always counts from zero

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      state <= TMC_ST_STOP;
    end else begin
      case (state)
        TMC_ST_STOP: begin
          if (ctrl.run) begin
            state <= TMC_ST_WAIT;
          end
        end
        TMC_ST_WAIT: begin
          state <= ctrl.run ? TMC_ST_RUN : TMC_ST_STOP;
        end
        TMC_ST_RUN: begin
          if (!ctrl.run) begin
            state <= TMC_ST_STOP;
          end
        end
        default: begin
          state <= TMC_ST_STOP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, captures and events

  // Event mode waits for the opposite edge before reporting the match
  // Timer mode matches on the tick after the count reaches the compare
  assign match_hit = (ctrl.clk_sel == tmc_pkg::TMC_CLK_EXT)
                     ? (opp_edge && cnt == cca) : (tick_int && cnt == cca);
  // The zero left by a match is skipped for one cycle only
  assign next_cap_b_timer = ctrl.auto_cap && !after_match;

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      cnt <= 8'h00;
      cca <= tmc_pkg::TMC_CCA_RST;
      capb <= tmc_pkg::TMC_CAPB_RST;
      evt <= '0;
      cap_hold <= 1'b0;
      after_match <= 1'b0;
    end else begin
      evt <= '0;
      if (reg_write(wb_wr, WB_SEL_IN, WB_ADR_IN, tmc_pkg::TMC_OFF_CCA)) begin
        cca <= byte_merge(cca, WB_DAT_IN, 1'b1);
      end
      // Reading the compare register is what re-arms capture after a wrap
      if (rd_cca) begin
        cap_hold <= 1'b0;
      end
      if (state != TMC_ST_RUN) begin
        cnt <= 8'h00;
        after_match <= 1'b0;
        cap_hold <= 1'b0;
      end else if (!ctrl.capture_mode) begin
        after_match <= 1'b0;
        if (match_hit) begin
          cnt <= 8'h00;
          evt.match <= 1'b1;
          after_match <= 1'b1;
        end else if (src_tick) begin
          cnt <= cnt + 8'h01;
        end
        if (next_cap_b_timer) begin
          capb <= cnt;
        end
      end else begin
        // Capture mode: B on the edge before the interrupt edge, A on the
        // interrupt edge, so a first edge that interrupts leaves B untouched
        if (!cap_hold && opp_edge) begin
          capb <= cnt;
        end
        // The interrupt edge is the counting edge of event mode
        if (!cap_hold && cnt_edge) begin
          cca <= cnt;
          cnt <= 8'h00;
          evt.capt <= 1'b1;
        end else if (tick_int) begin
          // A tick on the same cycle as an interrupt edge is not counted
          // Ticks on a B edge still count and still check for the wrap
          if (cnt == tmc_pkg::TMC_CNT_MAX) begin
            cnt <= 8'h00;
            // While held the counter still wraps, but reports nothing
            if (!cap_hold) begin
              cca <= tmc_pkg::TMC_CCA_RST;
              evt.ovf <= 1'b1;
              cap_hold <= 1'b1;
            end
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: a new event wins over a write-one clear
  // Pulse and level are registered once more so both leave flip-flops

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      status <= '0;
    end else begin
      if (reg_write(wb_wr, WB_SEL_IN, WB_ADR_IN, tmc_pkg::TMC_OFF_STAT)) begin
        status <= (status & ~WB_DAT_IN[2:0]) | evt;
      end else begin
        status <= status | evt;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      MATCH_PULSE_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      MATCH_PULSE_OUT <= |evt;
      IRQ_OUT <= |(status & mask);
    end
  end

endmodule
